/* File: rtu_link_pkg.sv */
// constants, types and crc helper for the serial request/response engine
// assumes a single core clock; the parameter map lives outside the engine
package rtu_link_pkg;

    // ******************************
    // timing
    // ******************************
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned RATE_9600     = 9600;
    localparam int unsigned RATE_19200    = 19200;
    localparam int unsigned RATE_38400    = 38400;
    localparam int unsigned RATE_57600    = 57600;
    localparam int unsigned RATE_115200   = 115200;
    localparam int unsigned CHAR_BITS     = 11;   // start, 8 data, parity, stop
    localparam int unsigned GAP_HALF_CHARS = 7;   // 3.5 characters

    // ******************************
    // frame layout
    // ******************************
    localparam logic [7:0] FN_READ_HOLD   = 8'h03;
    localparam logic [7:0] FN_WRITE_ONE   = 8'h06;
    localparam logic [7:0] FN_WRITE_MANY  = 8'h10;
    localparam logic [7:0] BROADCAST      = 8'h00;
    localparam logic [7:0] NODE_MAX       = 8'h20;
    localparam logic [3:0] MAX_REGS       = 4'h8;
    localparam logic [5:0] FIXED_REQ_LEN  = 6'h08;
    localparam logic [5:0] MANY_HDR_LEN   = 6'h09;
    localparam logic [5:0] ECHO_LEN       = 6'h06;
    localparam logic [5:0] READ_HDR_LEN   = 6'h03;
    localparam int unsigned BUF_DEPTH     = 32;
    localparam logic [15:0] CRC_INIT      = 16'hffff;
    localparam logic [15:0] CRC_POLY      = 16'ha001;

    typedef enum logic [2:0] {
        BAUD_9600, BAUD_19200, BAUD_38400, BAUD_57600, BAUD_115200
    } baud_t;

    typedef struct packed {
        logic [7:0] node_addr;
        baud_t      baud;
        logic       parity_odd;
    } link_cfg_t;

    typedef struct packed {
        logic        en;
        logic [15:0] addr;
        logic [15:0] data;
    } reg_wr_t;

    function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                              input logic [7:0]  b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

endpackage

/* File: rtu_slave_link.sv */
// serial slave engine: receives requests, serves functions 03/06/16
// assumes cfg and reg_rd_data come from logic on core_clk; rx_pin is async
// and the parameter map returns reg_rd_data one cycle after reg_rd_req
//
// Functional notes
// - answer only own node address 1..32
// - bit rate selectable 9600 to 115200
// - 8 data bits, odd/even parity, 1 stop
// - binary framing only, no text mode
// - address, function, data, two crc bytes
// - transmit only in reply to own request
// - response starts with own node address
// - broadcast address zero is ignored
// - crc-16, low byte sent first
// - register address equals parameter number, zero based
// - 32-bit values span two registers, high first
// - read holding registers, at most 8
// - write single register, echo address and value
// - write multiple registers, at most 8
// - 3.5 character silence ends a frame
`timescale 1ns/1ps
module rtu_slave_link #(
    parameter int unsigned clk_hz = rtu_link_pkg::CLK_HZ
) (
    input  wire logic                    core_clk,
    input  wire logic                    srst,
    input  wire rtu_link_pkg::link_cfg_t cfg,
    input  wire logic                    rx_pin,
    output logic                         tx_pin,
    output logic                         tx_drive_en,
    output logic                         reg_rd_req,
    output logic [15:0]                  reg_rd_addr,
    input  wire logic [15:0]             reg_rd_data,
    output rtu_link_pkg::reg_wr_t        reg_wr
);

    // ******************************
    // bit timing
    // ******************************
    logic [31:0] rate;
    logic [15:0] bit_div;
    logic [23:0] gap_cycles;

    always_comb begin
        case (cfg.baud)
            rtu_link_pkg::BAUD_19200: rate = rtu_link_pkg::RATE_19200;
            rtu_link_pkg::BAUD_38400: rate = rtu_link_pkg::RATE_38400;
            rtu_link_pkg::BAUD_57600: rate = rtu_link_pkg::RATE_57600;
            rtu_link_pkg::BAUD_115200: rate = rtu_link_pkg::RATE_115200;
            default: rate = rtu_link_pkg::RATE_9600;
        endcase
        bit_div = 16'(clk_hz / rate);
        gap_cycles = 24'((32'(bit_div) * rtu_link_pkg::CHAR_BITS
                          * rtu_link_pkg::GAP_HALF_CHARS) >> 1);
    end

    // ******************************
    // receiver
    // ******************************
    logic        rx_meta;
    logic        rx_sync;
    logic        rx_active;
    logic [15:0] rx_tmr;
    logic [3:0]  rx_bit;
    logic [9:0]  rx_sh;
    logic        rx_byte;
    logic        rx_err;
    logic [7:0]  rx_data;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= rx_pin;
            rx_sync <= rx_meta;
        end
    end

    always_ff @(posedge core_clk) begin
        rx_byte <= 1'b0;
        if (srst) begin
            rx_active <= 1'b0;
            rx_tmr    <= '0;
            rx_bit    <= '0;
            rx_sh     <= '0;
            rx_err    <= 1'b0;
        end else if (!rx_active) begin
            if (!rx_sync) begin
                rx_active <= 1'b1;
                rx_tmr    <= bit_div >> 1;
                rx_bit    <= '0;
            end
        end else if (rx_tmr != '0) begin
            rx_tmr <= rx_tmr - 16'h0001;
        end else begin
            rx_tmr <= bit_div - 16'h0001;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && rx_sync) begin
                rx_active <= 1'b0;  // start glitch, drop it
            end else if (rx_bit == 4'ha) begin
                rx_active <= 1'b0;
                rx_byte   <= 1'b1;
                // parity over data plus parity bit, then stop bit
                rx_err <= ((^rx_sh[9:1]) != cfg.parity_odd) || !rx_sync;
            end else begin
                rx_sh <= {rx_sync, rx_sh[9:1]};
            end
        end
    end

    assign rx_data = rx_sh[8:1];

    // ******************************
    // frame collection
    // ******************************
    typedef enum logic [2:0] {
        S_RX, S_CHECK, S_READ, S_WRITE, S_TX, S_DRAIN
    } state_t;

    state_t      state;
    logic [7:0]  rx_buf [rtu_link_pkg::BUF_DEPTH];
    logic [5:0]  rx_len;
    logic        rx_bad;
    logic [15:0] rx_crc;
    logic [23:0] gap_tmr;
    logic        frame_end;

    always_ff @(posedge core_clk) begin
        if (srst || state != S_RX) begin
            gap_tmr <= '0;
        end else if (rx_active || rx_byte) begin
            gap_tmr <= '0;
        end else if (gap_tmr != gap_cycles) begin
            gap_tmr <= gap_tmr + 24'h000001;
        end
    end

    // line silence with bytes held closes the frame
    assign frame_end = state == S_RX && rx_len != '0
                       && gap_tmr == gap_cycles;

    always_ff @(posedge core_clk) begin
        if (srst || frame_end) begin
            rx_len <= '0;
            rx_bad <= 1'b0;
            rx_crc <= rtu_link_pkg::CRC_INIT;
        end else if (rx_byte && state == S_RX) begin
            if (rx_len == 6'(rtu_link_pkg::BUF_DEPTH - 1)) begin
                rx_bad <= 1'b1;  // too long for any served function
            end else begin
                rx_buf[rx_len[4:0]] <= rx_data;
                rx_len <= rx_len + 6'h01;
                rx_bad <= rx_bad || rx_err;
            end
            rx_crc <= rtu_link_pkg::crc_step(rx_crc, rx_data);
        end
    end

    // ******************************
    // request decode
    // ******************************
    logic [7:0]  fn;
    logic [15:0] start_addr;
    logic [15:0] qty;
    logic [5:0]  fr_len;
    logic        fr_bad;
    logic [15:0] fr_crc;
    logic        req_ok;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            fr_len <= '0;
            fr_bad <= 1'b1;
            fr_crc <= '0;
        end else if (frame_end) begin
            fr_len <= rx_len;
            fr_bad <= rx_bad;
            fr_crc <= rx_crc;
        end
    end

    assign fn         = rx_buf[1];
    assign start_addr = {rx_buf[2], rx_buf[3]};  // used as is
    assign qty        = {rx_buf[4], rx_buf[5]};

    always_comb begin
        req_ok = 1'b0;
        case (fn) // only binary frames with these codes are served
            rtu_link_pkg::FN_READ_HOLD:
                req_ok = fr_len == rtu_link_pkg::FIXED_REQ_LEN
                         && qty != '0
                         && qty <= 16'(rtu_link_pkg::MAX_REGS);
            rtu_link_pkg::FN_WRITE_ONE:
                req_ok = fr_len == rtu_link_pkg::FIXED_REQ_LEN;
            rtu_link_pkg::FN_WRITE_MANY:
                req_ok = qty != '0
                         && qty <= 16'(rtu_link_pkg::MAX_REGS)
                         && rx_buf[6] == {qty[6:0], 1'b0}
                         && fr_len == rtu_link_pkg::MANY_HDR_LEN
                                      + {qty[4:0], 1'b0};
            default: req_ok = 1'b0;
        endcase
        // residue of zero means crc matched
        req_ok = req_ok && !fr_bad && fr_crc == '0
                 && rx_buf[0] == cfg.node_addr
                 && cfg.node_addr != rtu_link_pkg::BROADCAST
                 && cfg.node_addr <= rtu_link_pkg::NODE_MAX;
    end

    // ******************************
    // sequencer
    // ******************************
    logic [3:0]  idx;
    logic        rd_pend;
    logic [3:0]  rd_cap;
    logic [15:0] rd_buf [rtu_link_pkg::MAX_REGS];
    logic [5:0]  tx_idx;
    logic [5:0]  tx_len;
    logic [7:0]  tx_byte;
    logic [15:0] tx_crc;
    logic        tx_busy;
    logic        tx_load;
    logic [4:0]  wr_pos;

    assign tx_len = fn == rtu_link_pkg::FN_READ_HOLD
                    ? rtu_link_pkg::READ_HDR_LEN + {qty[4:0], 1'b0}
                    : rtu_link_pkg::ECHO_LEN;
    assign tx_load = state == S_TX && !tx_busy && tx_idx < tx_len + 6'h02;
    assign wr_pos  = 5'h07 + {idx[3:0], 1'b0};

    always_comb begin
        logic [5:0] k;
        k = tx_idx - rtu_link_pkg::READ_HDR_LEN;
        if (tx_idx == 6'h00) begin
            tx_byte = cfg.node_addr;
        end else if (tx_idx == tx_len) begin
            tx_byte = tx_crc[7:0];
        end else if (tx_idx > tx_len) begin
            tx_byte = tx_crc[15:8];
        end else if (fn != rtu_link_pkg::FN_READ_HOLD || tx_idx == 6'h01) begin
            tx_byte = rx_buf[tx_idx[4:0]];             // echo
        end else if (tx_idx == 6'h02) begin
            tx_byte = {qty[6:0], 1'b0};
        end else if (!k[0]) begin
            tx_byte = rd_buf[k[3:1]][15:8];
        end else begin
            tx_byte = rd_buf[k[3:1]][7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= S_RX;
            idx   <= '0;
        end else begin
            case (state)
                S_RX: if (frame_end) state <= S_CHECK;
                S_CHECK: begin
                    idx <= '0;
                    if (!req_ok)
                        state <= S_RX;
                    else if (fn == rtu_link_pkg::FN_READ_HOLD)
                        state <= S_READ;
                    else
                        state <= S_WRITE;
                end
                S_READ: begin
                    if (idx != qty[3:0]) idx <= idx + 4'h1;
                    if (rd_cap == qty[3:0] && !rd_pend) state <= S_TX;
                end
                S_WRITE: begin
                    idx <= idx + 4'h1;
                    if (fn == rtu_link_pkg::FN_WRITE_ONE
                        || idx + 4'h1 == qty[3:0]) state <= S_TX;
                end
                S_TX: if (!tx_busy && !tx_load) state <= S_DRAIN;
                S_DRAIN: state <= S_RX;
                default: state <= S_RX;
            endcase
        end
    end

    // one read issued per cycle, captured on the next
    always_ff @(posedge core_clk) begin
        if (srst || state == S_CHECK) begin
            reg_rd_req  <= 1'b0;
            reg_rd_addr <= '0;
            rd_pend     <= 1'b0;
            rd_cap      <= '0;
        end else begin
            reg_rd_req  <= state == S_READ && idx != qty[3:0];
            reg_rd_addr <= start_addr + 16'(idx);
            rd_pend     <= reg_rd_req;
            if (rd_pend) begin
                rd_buf[rd_cap[2:0]] <= reg_rd_data;
                rd_cap <= rd_cap + 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            reg_wr <= '0;
        end else begin
            reg_wr.en   <= state == S_WRITE;
            reg_wr.addr <= start_addr + 16'(idx);
            reg_wr.data <= fn == rtu_link_pkg::FN_WRITE_ONE ? qty
                           : {rx_buf[wr_pos], rx_buf[wr_pos + 5'h01]};
        end
    end

    // ******************************
    // transmitter
    // ******************************
    logic [15:0] tx_tmr;
    logic [10:0] tx_sh;
    logic [3:0]  tx_bits;

    always_ff @(posedge core_clk) begin
        if (srst || state == S_CHECK) begin
            tx_idx <= '0;
            tx_crc <= rtu_link_pkg::CRC_INIT;
        end else if (tx_load) begin
            tx_idx <= tx_idx + 6'h01;
            if (tx_idx < tx_len)
                tx_crc <= rtu_link_pkg::crc_step(tx_crc, tx_byte);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            tx_busy <= 1'b0;
            tx_sh   <= '1;
            tx_tmr  <= '0;
            tx_bits <= '0;
        end else if (tx_load) begin
            tx_busy <= 1'b1;
            // stop, parity, data lsb first, start
            tx_sh   <= {1'b1, (^tx_byte) ^ cfg.parity_odd, tx_byte, 1'b0};
            tx_tmr  <= bit_div - 16'h0001;
            tx_bits <= '0;
        end else if (tx_busy) begin
            if (tx_tmr != '0) begin
                tx_tmr <= tx_tmr - 16'h0001;
            end else begin
                tx_tmr  <= bit_div - 16'h0001;
                tx_sh   <= {1'b1, tx_sh[10:1]};
                tx_bits <= tx_bits + 4'h1;
                if (tx_bits == 4'(rtu_link_pkg::CHAR_BITS - 1))
                    tx_busy <= 1'b0;
            end
        end
    end

    // driver enabled only while a reply is on the line
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tx_pin      <= 1'b1;
            tx_drive_en <= 1'b0;
        end else begin
            tx_pin      <= tx_busy ? tx_sh[0] : 1'b1;
            tx_drive_en <= tx_busy || state == S_TX;
        end
    end

endmodule // rtu_slave_link

/* File: rtu_slave_link_sva.sv */
// checker for the serial slave engine
// assumes it is bound to rtu_slave_link on core_clk
`timescale 1ns/1ps
module rtu_slave_link_sva #(
    parameter int unsigned clk_hz = rtu_link_pkg::CLK_HZ
) (
    input wire logic                    core_clk,
    input wire logic                    srst,
    input wire rtu_link_pkg::link_cfg_t cfg,
    input wire logic                    rx_pin,
    input wire logic                    tx_pin,
    input wire logic                    tx_drive_en,
    input wire logic                    reg_rd_req,
    input wire logic [15:0]             reg_rd_addr,
    input wire logic [15:0]             reg_rd_data,
    input wire rtu_link_pkg::reg_wr_t   reg_wr
);
    // ********************
    // run counters
    // ********************
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    logic [3:0] rd_run;
    logic [3:0] wr_run;
    always_ff @(posedge core_clk) begin
        rd_run <= (srst || !reg_rd_req) ? 4'h0 : rd_run + 4'h1;
    end
    always_ff @(posedge core_clk) begin
        wr_run <= (srst || !reg_wr.en) ? 4'h0 : wr_run + 4'h1;
    end
    sequence s_rd_two;
        reg_rd_req ##1 reg_rd_req;
    endsequence
    sequence s_wr_two;
        reg_wr.en ##1 reg_wr.en;
    endsequence
    a_rd_addr_step: assert property (
        s_rd_two |-> reg_rd_addr == $past(reg_rd_addr) + 16'h1)
        else $error("read address did not step");
    a_rd_burst_max: assert property (rd_run <= 4'h8)
        else $error("more than eight reads");
    a_wr_addr_step: assert property (
        s_wr_two |-> reg_wr.addr == $past(reg_wr.addr) + 16'h1)
        else $error("write address did not step");
    a_wr_burst_max: assert property (wr_run <= 4'h8)
        else $error("more than eight writes");
    a_no_rd_wr_mix: assert property (!(reg_rd_req && reg_wr.en))
        else $error("read and write together");
    a_quiet_on_tx: assert property (
        tx_drive_en |-> !reg_rd_req && !reg_wr.en)
        else $error("register access while replying");
    a_start_driven: assert property (
        $fell(tx_pin) |-> ##[0:2] tx_drive_en)
        else $error("start bit without driver");
    a_release_idle: assert property (
        $fell(tx_drive_en) |-> tx_pin)
        else $error("driver released off stop level");
    a_bad_node_mute: assert property (
        (cfg.node_addr == 8'h00 || cfg.node_addr > rtu_link_pkg::NODE_MAX)
        |-> !$rose(tx_drive_en))
        else $error("reply with invalid node");
endmodule // rtu_slave_link_sva

bind rtu_slave_link rtu_slave_link_sva #(.clk_hz(clk_hz)) sva_inst (
    .core_clk(core_clk), .srst(srst), .cfg(cfg), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .tx_drive_en(tx_drive_en), .reg_rd_req(reg_rd_req),
    .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .reg_wr(reg_wr));

/* File: rtu_master.sv */
// bus master model: sends requests, collects replies
// assumes bus_in is the biased line level, idle high
`timescale 1ns/1ps
module rtu_master #(
    parameter int unsigned clk_hz = rtu_link_pkg::CLK_HZ
) (
    input  wire logic                    core_clk,
    input  wire rtu_link_pkg::link_cfg_t cfg,
    output logic                         bus_out,
    input  wire logic                    bus_in
);
    // ********************
    // character timing
    // ********************
    localparam int unsigned rates[5] = '{9600, 19200, 38400, 57600, 115200};
    logic [7:0] tx_q [$];
    logic [7:0] rx_q [$];
    int         perr = 0;
    initial bus_out = 1'b1;
    function automatic int bit_cyc();
        return clk_hz / rates[cfg.baud];
    endfunction
    function automatic logic par(input logic [7:0] b);
        return cfg.parity_odd ? ~^b : ^b;
    endfunction
    function automatic logic [15:0] crc_of(input logic [7:0] q [$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    // split >= 0 inserts a silence long enough to end the frame there
    task automatic send(input bit bad, input int split);
        logic [15:0] c;
        logic [10:0] sh;
        c = crc_of(tx_q) ^ {15'h0, bad};
        tx_q.push_back(c[7:0]);
        tx_q.push_back(c[15:8]);
        foreach (tx_q[k]) begin
            if (k == split)
                repeat (55 * bit_cyc()) @(posedge core_clk);
            sh = {1'b1, par(tx_q[k]), tx_q[k], 1'b0};
            for (int j = 0; j < 11; j++) begin
                @(posedge core_clk);
                #1 bus_out = sh[j];
                repeat (bit_cyc() - 1) @(posedge core_clk);
            end
        end
    endtask
    task automatic recv(input int lim);
        int          idle;
        logic [10:0] sh;
        rx_q.delete();
        idle = 0;
        while (idle < lim * bit_cyc()) begin
            @(posedge core_clk);
            #1;
            idle++;
            if (bus_in === 1'b0) begin
                repeat (bit_cyc() / 2) @(posedge core_clk);
                for (int j = 0; j < 10; j++) begin
                    repeat (bit_cyc()) @(posedge core_clk);
                    sh[j] = bus_in;
                end
                if (sh[8] !== par(sh[7:0]) || sh[9] !== 1'b1) perr++;
                rx_q.push_back(sh[7:0]);
                idle = 0;
                lim = 44;
            end
        end
    endtask
endmodule // rtu_master

/* File: rtu_slave_link_tb_top.sv */
// self-checking bench for the serial slave engine
// assumes the checker and master model are compiled first
`timescale 1ns/1ps
module rtu_slave_link_tb_top;
    localparam int unsigned clk_hz = 1_152_000;
    logic                    core_clk;
    logic                    srst;
    rtu_link_pkg::link_cfg_t cfg;
    logic                    rx_pin;
    logic                    tx_pin;
    logic                    tx_drive_en;
    logic                    reg_rd_req;
    logic [15:0]             reg_rd_addr;
    logic [15:0]             reg_rd_data = 16'h0000;
    rtu_link_pkg::reg_wr_t   reg_wr;
    logic                    bus;
    logic [31:0]             wr_q [$];
    logic [7:0]              exp_q [$];
    int                      rd_cnt = 0;
    int                      failures = 0;
    int                      checked = 0;
    assign bus = tx_drive_en ? tx_pin : 1'b1; // line bias
    rtu_slave_link #(.clk_hz(clk_hz)) rtu_slave_link_inst (
        .core_clk(core_clk), .srst(srst), .cfg(cfg), .rx_pin(rx_pin),
        .tx_pin(tx_pin), .tx_drive_en(tx_drive_en), .reg_rd_req(reg_rd_req),
        .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .reg_wr(reg_wr));
    rtu_master #(.clk_hz(clk_hz)) rtu_master_inst (
        .core_clk(core_clk), .cfg(cfg), .bus_out(rx_pin), .bus_in(bus));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // ********************
    // parameter map stand-in
    // ********************
    // data lands a cycle after the request; junk otherwise
    always @(posedge core_clk) begin
        if (reg_rd_req === 1'b1) begin
            reg_rd_data <= #1 reg_rd_addr ^ 16'hc3a5;
            rd_cnt++;
        end else begin
            reg_rd_data <= #1 ~reg_rd_data;
        end
        if (reg_wr.en === 1'b1) wr_q.push_back({reg_wr.addr, reg_wr.data});
    end
    task automatic results();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check_num(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_frame();
        logic bad;
        checked++;
        bad = rtu_master_inst.rx_q.size() != exp_q.size();
        foreach (exp_q[i]) bad |= rtu_master_inst.rx_q[i] !== exp_q[i];
        if (bad) begin
            failures++;
            $display("ERROR %0t: reply frame differs", $time);
        end
    endtask
    // empty exp_q means silence is expected
    task automatic xfer(input bit bad, input int split);
        logic [15:0] c;
        wr_q.delete();
        rd_cnt = 0;
        rtu_master_inst.send(bad, split);
        rtu_master_inst.recv(88);
        c = rtu_master_inst.crc_of(exp_q);
        if (exp_q.size() > 0) exp_q = {exp_q, c[7:0], c[15:8]};
        check_frame();
    endtask
    initial begin
        repeat (100000) @(posedge core_clk);
        failures++;
        results();
    end
    // ********************
    // scenarios
    // ********************
    initial begin
        int          n;
        logic [15:0] v;
        srst = 1'b1;
        cfg.node_addr = 8'h01;
        cfg.baud = rtu_link_pkg::BAUD_9600;
        cfg.parity_odd = 1'b0;
        repeat (6) @(posedge core_clk);
        #1 srst = 1'b0;
        rtu_master_inst.recv(20);
        check_frame();
        for (int i = 0; i < 5; i++) begin
            n = (i == 0) ? 1 : 2 * i;
            cfg.baud = rtu_link_pkg::baud_t'(i);
            cfg.parity_odd = i[0];
            rtu_master_inst.tx_q = '{8'h01, 8'h03, 8'h00, 8'(i), 8'h00, 8'(n)};
            exp_q = '{8'h01, 8'h03, 8'(2 * n)};
            for (int k = 0; k < n; k++) begin
                v = 16'(i + k) ^ 16'hc3a5;
                exp_q = {exp_q, v[15:8], v[7:0]};
            end
            xfer(1'b0, -1);
            check_num(32'(rd_cnt), 32'(n));
        end
        cfg.node_addr = 8'h20;
        rtu_master_inst.tx_q = '{8'h20, 8'h06, 8'h00, 8'h0c, 8'h00, 8'h09};
        exp_q = '{8'h20, 8'h06, 8'h00, 8'h0c, 8'h00, 8'h09};
        xfer(1'b0, -1);
        check_num(wr_q[0], 32'h000c0009);
        rtu_master_inst.tx_q = '{8'h20, 8'h10, 8'h00, 8'h40, 8'h00, 8'h03,
            8'h06, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc};
        exp_q = '{8'h20, 8'h10, 8'h00, 8'h40, 8'h00, 8'h03};
        xfer(1'b0, -1);
        check_num(32'(wr_q.size()), 32'h3);
        check_num(wr_q[0], 32'h00401234);
        check_num(wr_q[2], 32'h00429abc);
        for (int i = 0; i < 7; i++) begin
            exp_q.delete();
            n = 1;
            case (i)
                0: v = 16'h2103;
                1: v = 16'h0006;
                2: begin
                    v = 16'h2003;
                    n = 9;
                end
                3: v = 16'h3a32;
                6: begin
                    v = 16'h2106;
                    cfg.node_addr = 8'h21;
                end
                default: v = 16'h2006;
            endcase
            // six-byte request, each refused by one fault alone except case 3, where both node and function are wrong
            rtu_master_inst.tx_q = '{v[15:8], v[7:0], 8'h00, 8'h01, 8'h00,
                8'(n)};
            xfer(i == 4, (i == 5) ? 3 : -1);
            check_num(32'(wr_q.size()) + 32'(rd_cnt), 32'h0);
        end
        check_num(32'(rtu_master_inst.perr), 32'h0);
        results();
    end
endmodule // rtu_slave_link_tb_top
